// ===== hdl/ordt_orient_regs.sv
// orientation detection: debounce, status, config and count registers
`timescale 1ns/1ns

// Function
// - change flag set on first detection, changes
// - status register read clears change flag
// - status read also clears pending interrupt
// - orientation fields keep tracking while flag set
// - hold orientation while any axis exceeds 1.25g
// - status bit 6 reports tilt lockout
// - bits 2:1 encode orientation code
// - bit 0 reports back or front face
// - all status fields zero after reset
// - config bit 6 enables detection, resets 0
// - mode 0 decrements counter when condition lapses
// - mode 1 clears counter, mode resets to 1
// - debounce count register eight bits, resets zero
// - commit latency is count plus one steps
// - wake or sleep transition resets counter
// - normal mode step follows sample period, capped at 20 ms below 50 Hz
// - step differs per oversampling mode
module ordt_orient_regs #(
	parameter int CYC_PER_US = ordt_pkg::CLK_MHZ
) (
	// clock and reset
	input wire logic CLK,
	input wire logic NRST,
	// register port
	input wire logic [7:0] REG_ADDR,
	input wire logic REG_WR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	output logic REG_RVALID,
	// sensing path, asynchronous to CLK
	input wire logic SAMPLE_CLK,
	input wire ordt_pkg::ordt_orient_t CANDIDATE,
	input wire logic OVER_1G25,
	input wire logic ACTIVE,
	input wire logic WAKE,
	// rate selection from the device's other settings
	input wire ordt_pkg::ordt_rate_t OUTPUT_SAMPLE_RATE,
	input wire ordt_pkg::ordt_os_t OVERSAMPLING_MODE,
	// orientation event output
	output logic ORIENT_IRQ
);

	typedef enum logic [1:0] {
		ST_OFF, ST_FIRST, ST_TRACK
	} ordt_state_t;

	initial begin
		if (CYC_PER_US < 1) begin
			$error("CYC_PER_US must be at least 1");
		end
	end

	////////////////////////////////////////////////////////////////////////
	// reset release

	logic rst_meta_reg;
	logic rst_n;

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			rst_meta_reg <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n <= rst_meta_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// input synchronisers

	localparam int SYNC_W = 8;

	logic [SYNC_W-1:0] sync_meta_reg;
	logic [SYNC_W-1:0] sync_reg;
	logic [SYNC_W-1:0] pins;
	logic sclk_prev_reg;
	logic sample_edge;
	logic over_g;
	logic active_s;
	logic wake_s;
	logic active_prev_reg;
	logic wake_prev_reg;
	ordt_pkg::ordt_orient_t cand_s;

	assign pins = {SAMPLE_CLK, OVER_1G25, ACTIVE, WAKE, CANDIDATE};

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			sync_meta_reg <= '0;
			sync_reg <= '0;
			sclk_prev_reg <= 1'b0;
			active_prev_reg <= 1'b0;
			wake_prev_reg <= 1'b0;
		end else begin
			sync_meta_reg <= pins;
			sync_reg <= sync_meta_reg;
			sclk_prev_reg <= sync_reg[7];
			active_prev_reg <= active_s;
			wake_prev_reg <= wake_s;
		end
	end

	assign sample_edge = sync_reg[7] && !sclk_prev_reg;
	assign over_g = sync_reg[6];
	assign active_s = sync_reg[5];
	assign wake_s = sync_reg[4];
	assign cand_s = ordt_pkg::ordt_orient_t'(sync_reg[3:0]);

	////////////////////////////////////////////////////////////////////////
	// register writes

	logic debounce_mode_reg;
	logic enable_reg;
	logic [7:0] debounce_value_reg;
	logic wr_config;
	logic wr_count;

	assign wr_config = REG_WR && (REG_ADDR == ordt_pkg::ADDR_CONFIG);
	assign wr_count = REG_WR && (REG_ADDR == ordt_pkg::ADDR_COUNT);

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			debounce_mode_reg <= ordt_pkg::RST_DEBOUNCE_MODE;
			enable_reg <= ordt_pkg::RST_ENABLE;
			debounce_value_reg <= ordt_pkg::RST_DEBOUNCE_VALUE;
		end else begin
			if (wr_config) begin
				debounce_mode_reg <= REG_WDATA[ordt_pkg::CFG_MODE_BIT];
				enable_reg <= REG_WDATA[ordt_pkg::CFG_ENABLE_BIT];
			end
			if (wr_count) begin
				debounce_value_reg <= REG_WDATA;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sample capture and step timing

	ordt_pkg::ordt_orient_t cand_reg;
	logic step_tick;
	logic activated;
	logic power_change;

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			cand_reg <= ordt_pkg::RST_ORIENT;
		end else if (sample_edge) begin
			cand_reg <= cand_s;
		end
	end

	assign activated = active_s && !active_prev_reg;
	assign power_change = wake_s != wake_prev_reg;

	logic clk_w;
	assign clk_w = CLK;

	ordt_step_timer #(
		.CYC_PER_US(CYC_PER_US)
	) u_step_timer (
		.clk(clk_w),
		.rst_n(rst_n),
		.rate(OUTPUT_SAMPLE_RATE),
		.os_mode(OVERSAMPLING_MODE),
		.restart(power_change || !enable_reg),
		.step_tick(step_tick)
	);

	////////////////////////////////////////////////////////////////////////
	// debounce and state commit

	ordt_state_t state_reg;
	ordt_state_t state_next;
	ordt_pkg::ordt_orient_t orient_reg;
	ordt_pkg::ordt_orient_t orient_next;
	logic [7:0] cnt_reg;
	logic [7:0] cnt_next;
	logic commit;
	logic differs;

	assign differs = cand_reg != orient_reg;

	always_comb begin
		state_next = state_reg;
		orient_next = orient_reg;
		cnt_next = cnt_reg;
		commit = 1'b0;
		case (state_reg)
			ST_OFF: begin
				cnt_next = '0;
				if (enable_reg && active_s) begin
					state_next = ST_FIRST;
				end
			end
			ST_FIRST: begin
				if (step_tick && !over_g) begin
					orient_next = cand_reg;
					commit = 1'b1;
					state_next = ST_TRACK;
				end
			end
			ST_TRACK: begin
				if (step_tick && !over_g) begin
					if (differs) begin
						if (cnt_reg >= debounce_value_reg) begin
							orient_next = cand_reg;
							commit = 1'b1;
							cnt_next = '0;
						end else begin
							cnt_next = cnt_reg + 8'h01;
						end
					end else if (debounce_mode_reg) begin
						cnt_next = '0;
					end else if (cnt_reg != 8'h00) begin
						cnt_next = cnt_reg - 8'h01;
					end
				end
			end
			default: begin
				state_next = ST_OFF;
			end
		endcase
		if (power_change) begin
			cnt_next = '0;
		end
		if (!enable_reg || !active_s) begin
			state_next = ST_OFF;
			orient_next = orient_reg;
			commit = 1'b0;
			cnt_next = '0;
		end else if (activated) begin
			state_next = ST_FIRST;
			cnt_next = '0;
		end
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_OFF;
			orient_reg <= ordt_pkg::RST_ORIENT;
			cnt_reg <= '0;
		end else begin
			state_reg <= state_next;
			orient_reg <= orient_next;
			cnt_reg <= cnt_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// change flag and event output

	logic flag_reg;
	logic flag_next;
	logic rd_status;

	assign rd_status = REG_RD && (REG_ADDR == ordt_pkg::ADDR_STATUS);
	// a commit in the read cycle keeps the flag set
	assign flag_next = commit || (flag_reg && !rd_status);

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			flag_reg <= 1'b0;
			ORIENT_IRQ <= 1'b0;
		end else begin
			flag_reg <= flag_next;
			ORIENT_IRQ <= flag_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register reads

	logic [7:0] status_word;
	logic [7:0] config_word;
	logic [7:0] rd_word;

	always_comb begin
		status_word = '0;
		status_word[ordt_pkg::STS_CHANGE_BIT] = flag_reg;
		status_word[ordt_pkg::STS_LOCKOUT_BIT] = orient_reg.tilt_lockout;
		status_word[ordt_pkg::STS_CODE_HI:ordt_pkg::STS_CODE_LO] =
			orient_reg.orient_code;
		status_word[ordt_pkg::STS_FACE_BIT] = orient_reg.back_front_face;
		config_word = '0;
		config_word[ordt_pkg::CFG_MODE_BIT] = debounce_mode_reg;
		config_word[ordt_pkg::CFG_ENABLE_BIT] = enable_reg;
	end

	assign rd_word = (REG_ADDR == ordt_pkg::ADDR_STATUS) ? status_word :
		(REG_ADDR == ordt_pkg::ADDR_CONFIG) ? config_word :
		(REG_ADDR == ordt_pkg::ADDR_COUNT) ? debounce_value_reg :
		ordt_pkg::RST_READ_DATA;

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			REG_RDATA <= ordt_pkg::RST_READ_DATA;
			REG_RVALID <= 1'b0;
		end else begin
			REG_RVALID <= REG_RD;
			if (REG_RD) begin
				REG_RDATA <= rd_word;
			end
		end
	end

endmodule : ordt_orient_regs

// ===== hdl/ordt_pkg.sv
// package: register map, field layout, step table and carrier types
package ordt_pkg;

	// register offsets
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_CONFIG = 8'h11;
	localparam logic [7:0] ADDR_COUNT = 8'h12;

	// status field positions
	localparam int STS_CHANGE_BIT = 7;
	localparam int STS_LOCKOUT_BIT = 6;
	localparam int STS_CODE_HI = 2;
	localparam int STS_CODE_LO = 1;
	localparam int STS_FACE_BIT = 0;

	// config field positions
	localparam int CFG_MODE_BIT = 7;
	localparam int CFG_ENABLE_BIT = 6;

	// reset values
	localparam logic RST_DEBOUNCE_MODE = 1'b1;
	localparam logic RST_ENABLE = 1'b0;
	localparam logic [7:0] RST_DEBOUNCE_VALUE = 8'h00;
	localparam logic [7:0] RST_READ_DATA = 8'h00;

	// debounce step lengths in microseconds
	localparam int STEP_US_800 = 1250;
	localparam int STEP_US_400 = 2500;
	localparam int STEP_US_200 = 5000;
	localparam int STEP_US_100 = 10000;
	localparam int STEP_US_50 = 20000;
	localparam int STEP_US_80MS = 80000;
	localparam int STEP_US_160MS = 160000;
	localparam int STEP_US_MAX = STEP_US_160MS;

	// clock rate of the block in MHz (40 ns period)
	localparam int CLK_MHZ = 25;

	// width of the step timer
	localparam int STEP_TIMER_W = 24;

	// output sample rate select
	typedef enum logic [2:0] {
		RATE_800, RATE_400, RATE_200, RATE_100,
		RATE_50, RATE_12P5, RATE_6P25, RATE_1P56
	} ordt_rate_t;

	// oversampling mode select
	typedef enum logic [1:0] {
		OS_NORMAL, OS_LOW_NOISE_LOW_POWER, OS_HIGH_RES, OS_LOW_POWER
	} ordt_os_t;

	// orientation state as reported in the status register
	typedef struct packed {
		logic tilt_lockout;
		logic [1:0] orient_code;
		logic back_front_face;
	} ordt_orient_t;

	localparam ordt_orient_t RST_ORIENT = '0;

endpackage : ordt_pkg

// ===== hdl/ordt_step_timer.sv
// debounce step timer: one pulse per step, length set by rate and mode
`timescale 1ns/1ns
module ordt_step_timer #(
	parameter int CYC_PER_US = ordt_pkg::CLK_MHZ
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// selection
	input wire ordt_pkg::ordt_rate_t rate,
	input wire ordt_pkg::ordt_os_t os_mode,
	input wire logic restart,
	// step pulse
	output logic step_tick
);

	localparam int W = ordt_pkg::STEP_TIMER_W;

	initial begin
		if (CYC_PER_US < 1 ||
			64'(CYC_PER_US) * 64'(ordt_pkg::STEP_US_MAX) >= (64'd1 << W)) begin
			$error("step timer cannot serve CYC_PER_US");
		end
	end

	int step_us;
	logic [W-1:0] step_cycles;
	logic [W-1:0] timer_reg;
	logic [W-1:0] timer_next;
	logic tick_next;

	// step length per rate and oversampling mode
	always_comb begin
		case (rate)
			ordt_pkg::RATE_800: step_us = ordt_pkg::STEP_US_800;
			ordt_pkg::RATE_400: step_us = ordt_pkg::STEP_US_400;
			ordt_pkg::RATE_200: step_us = ordt_pkg::STEP_US_200;
			ordt_pkg::RATE_100: step_us = ordt_pkg::STEP_US_100;
			ordt_pkg::RATE_50: step_us = ordt_pkg::STEP_US_50;
			ordt_pkg::RATE_12P5: step_us = ordt_pkg::STEP_US_80MS;
			default: step_us = ordt_pkg::STEP_US_160MS;
		endcase
		case (os_mode)
			ordt_pkg::OS_NORMAL: begin
				if (step_us > ordt_pkg::STEP_US_50) begin
					step_us = ordt_pkg::STEP_US_50;
				end
			end
			ordt_pkg::OS_HIGH_RES: begin
				if (step_us > ordt_pkg::STEP_US_400) begin
					step_us = ordt_pkg::STEP_US_400;
				end
			end
			ordt_pkg::OS_LOW_NOISE_LOW_POWER: begin
				if (step_us > ordt_pkg::STEP_US_80MS) begin
					step_us = ordt_pkg::STEP_US_80MS;
				end
			end
			default: step_us = step_us;
		endcase
		step_cycles = W'(step_us * CYC_PER_US);
	end

	assign tick_next = !restart && (timer_reg >= step_cycles - W'(1));
	assign timer_next = (restart || tick_next) ? '0 : timer_reg + W'(1);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			timer_reg <= '0;
			step_tick <= 1'b0;
		end else begin
			timer_reg <= timer_next;
			step_tick <= tick_next;
		end
	end

endmodule : ordt_step_timer

// ===== test/ordt_orient_regs_assertions.sv
// checker: register port answers and change flag relations
`timescale 1ns/1ns
module ordt_orient_regs_checker (
	// clock and reset
	input wire logic CLK,
	input wire logic NRST,
	// register port
	input wire logic [7:0] REG_ADDR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_RDATA,
	input wire logic REG_RVALID,
	// event
	input wire logic ORIENT_IRQ
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!NRST);
	wire logic st_rd = REG_RD && REG_ADDR == ordt_pkg::ADDR_STATUS;
	wire logic cf_rd = REG_RD && REG_ADDR == ordt_pkg::ADDR_CONFIG;
	wire logic hit = st_rd || cf_rd || REG_ADDR == ordt_pkg::ADDR_COUNT;
	rd_answer_a: assert property (REG_RD |=> REG_RVALID)
		else $error("read not answered");
	rvalid_cause_a: assert property (REG_RVALID |-> $past(REG_RD))
		else $error("answer without read");
	flag_reported_a: assert property (st_rd && ORIENT_IRQ |=> REG_RDATA[7])
		else $error("set flag not reported");
	flag_clear_a: assert property ($fell(ORIENT_IRQ) |-> $past(st_rd))
		else $error("flag dropped without status read");
	flag_hold_a: assert property (ORIENT_IRQ && !st_rd |=> ORIENT_IRQ)
		else $error("flag dropped early");
	spare_bits_a: assert property (st_rd |=> REG_RDATA[5:3] == 3'b000)
		else $error("status spare bits set");
	cfg_spare_a: assert property (cf_rd |=> REG_RDATA[5:0] == 6'h00)
		else $error("config spare bits set");
	unmapped_zero_a: assert property (REG_RD && !hit |=> REG_RDATA == 8'h00)
		else $error("unmapped read not zero");
	rdata_hold_a: assert property (!REG_RVALID |-> $stable(REG_RDATA))
		else $error("read data moved without read");
endmodule : ordt_orient_regs_checker
////////////////////////////////////////////////////////////////////////////////
bind ordt_orient_regs ordt_orient_regs_checker u_chk (.CLK(CLK), .NRST(NRST),
	.REG_ADDR(REG_ADDR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
	.REG_RVALID(REG_RVALID), .ORIENT_IRQ(ORIENT_IRQ));

// ===== test/ordt_host_model.sv
// host model: one-cycle register strobes, released lines inverted
`timescale 1ns/1ns
module ordt_host_model (
	// clock
	input wire logic clk,
	// register port
	output logic [7:0] reg_addr,
	output logic reg_wr,
	output logic [7:0] reg_wdata,
	output logic reg_rd
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clk);
		#1;
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clk);
		#1;
		reg_rd = 1'b0;
		reg_addr = ~a;
	endtask : rd
endmodule : ordt_host_model

// ===== test/testbench.sv
// testbench: orientation registers driven by host model and sensing stimulus
`timescale 1ns/1ns
module testbench;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic sample_clk = 1'b0;
	ordt_pkg::ordt_orient_t cand = '0;
	ordt_pkg::ordt_orient_t last;
	logic over = 1'b0;
	logic active = 1'b0;
	logic wake = 1'b1;
	ordt_pkg::ordt_rate_t rate = ordt_pkg::RATE_800;
	ordt_pkg::ordt_os_t os = ordt_pkg::OS_NORMAL;
	logic [7:0] addr, wdata, rdata;
	logic wr, rd, rvalid, irq;
	logic [7:0] exp_q[$];
	int err_total = 0;
	int total_checks = 0;
	int seed = 32'h35ca;
	int n;
	always #20 clk = ~clk;
	always #160 sample_clk = ~sample_clk;
	ordt_host_model u_host (.clk(clk), .reg_addr(addr), .reg_wr(wr),
		.reg_wdata(wdata), .reg_rd(rd));
	ordt_orient_regs #(.CYC_PER_US(1)) u_dut (.CLK(clk), .NRST(nrst),
		.REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wdata), .REG_RD(rd),
		.REG_RDATA(rdata), .REG_RVALID(rvalid), .SAMPLE_CLK(sample_clk),
		.CANDIDATE(cand), .OVER_1G25(over), .ACTIVE(active), .WAKE(wake),
		.OUTPUT_SAMPLE_RATE(rate), .OVERSAMPLING_MODE(os), .ORIENT_IRQ(irq));
	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic close_out;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : close_out
	task automatic expect_rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		u_host.rd(a);
	endtask : expect_rd
	function automatic logic [7:0] sts(input ordt_pkg::ordt_orient_t o,
		input logic f);
		return {f, o.tilt_lockout, 3'b000, o.orient_code, o.back_front_face};
	endfunction : sts
	task automatic tick(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask : tick
	task automatic wait_irq;
		n = 0;
		while (irq !== 1'b1 && n < 5000) begin
			@(posedge clk);
			n++;
		end
		#1;
	endtask : wait_irq
	// read monitor: oldest note against each answer
	always @(negedge clk) begin
		if (rvalid === 1'b1) begin
			check(rdata, exp_q.pop_front());
		end
	end
	initial begin
		#4000000;
		err_total++;
		close_out();
	end
	initial begin
		tick(6);
		nrst = 1'b1;
		tick(3);
		expect_rd(ordt_pkg::ADDR_STATUS, 8'h00);
		expect_rd(ordt_pkg::ADDR_CONFIG, 8'h80);
		expect_rd(ordt_pkg::ADDR_COUNT, 8'h00);
		expect_rd(8'h13, 8'h00);
		u_host.wr(ordt_pkg::ADDR_STATUS, 8'hff);
		u_host.wr(ordt_pkg::ADDR_COUNT, 8'h02);
		expect_rd(ordt_pkg::ADDR_STATUS, 8'h00);
		expect_rd(ordt_pkg::ADDR_COUNT, 8'h02);
		cand = 4'($random(seed));
		active = 1'b1;
		u_host.wr(ordt_pkg::ADDR_CONFIG, 8'hc0);
		wait_irq();
		check({7'h00, irq}, 8'h01);
		expect_rd(ordt_pkg::ADDR_STATUS, sts(cand, 1'b1));
		expect_rd(ordt_pkg::ADDR_STATUS, sts(cand, 1'b0));
		check({7'h00, irq}, 8'h00);
		cand.orient_code = ~cand.orient_code;
		wait_irq();
		check({7'h00, n >= 2490 && n <= 3765}, 8'h01);
		expect_rd(ordt_pkg::ADDR_STATUS, sts(cand, 1'b1));
		for (int i = 0; i < 8; i++) begin
			cand = {1'($random(seed)), 2'(i >> 1), 1'(i)};
			tick(5000);
			if (i % 2 == 1) begin
				expect_rd(ordt_pkg::ADDR_STATUS, sts(cand, 1'b1));
			end
		end
		// wake toggles closer than three steps keep the counter from committing
		last = cand;
		cand.orient_code = ~cand.orient_code;
		repeat (4) begin
			tick(2000);
			wake = ~wake;
		end
		expect_rd(ordt_pkg::ADDR_STATUS, sts(last, 1'b0));
		tick(5000);
		expect_rd(ordt_pkg::ADDR_STATUS, sts(cand, 1'b1));
		last = cand;
		over = 1'b1;
		cand.orient_code = ~cand.orient_code;
		tick(5000);
		expect_rd(ordt_pkg::ADDR_STATUS, sts(last, 1'b0));
		over = 1'b0;
		tick(5000);
		expect_rd(ordt_pkg::ADDR_STATUS, sts(cand, 1'b1));
		last = cand;
		u_host.wr(ordt_pkg::ADDR_CONFIG, 8'h00);
		expect_rd(ordt_pkg::ADDR_CONFIG, 8'h00);
		cand.back_front_face = ~cand.back_front_face;
		tick(5000);
		expect_rd(ordt_pkg::ADDR_STATUS, sts(last, 1'b0));
		rate = ordt_pkg::RATE_50;
		os = ordt_pkg::OS_HIGH_RES;
		u_host.wr(ordt_pkg::ADDR_COUNT, 8'h00);
		u_host.wr(ordt_pkg::ADDR_CONFIG, 8'h40);
		wait_irq();
		check({7'h00, n >= 2480 && n <= 2510}, 8'h01);
		expect_rd(ordt_pkg::ADDR_STATUS, sts(cand, 1'b1));
		tick(2);
		close_out();
	end
endmodule : testbench
